// file: bench/gdb_bus_cycle_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module gdb_bus_cycle_assertions(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic write_setup_select,
  input wire logic ext_long,
  input wire logic rsp_valid,
  input wire logic [23:0] bus_addr,
  input wire logic addr_strobe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic bus_data_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence wr_go;
    $fell(wr_n) && write_setup_select;
  endsequence
  chk_as_short_width: assert property ($fell(addr_strobe_n) && write_setup_select && !ext_long
    && !rd_n |-> !addr_strobe_n[*2] ##[1:4] addr_strobe_n) else $error("as width");
  chk_as_wr_width: assert property ($fell(addr_strobe_n) && write_setup_select && !ext_long
    && rd_n |-> !addr_strobe_n[*3] ##[1:4] addr_strobe_n) else $error("as wr width");
  chk_as_long_width: assert property ($fell(addr_strobe_n) && ext_long && !rd_n
    |-> !addr_strobe_n[*6] ##[1:7] addr_strobe_n) else $error("as long width");
  chk_as_addr_lead: assert property ($fell(addr_strobe_n) |-> bus_addr == $past(bus_addr) &&
    bus_addr != $past(bus_addr, 2)) else $error("as lead");
  chk_rd_short_width: assert property ($fell(rd_n) && !ext_long |-> !rd_n[*2] ##[1:4] rd_n)
    else $error("rd short width");
  chk_rd_long_width: assert property ($fell(rd_n) && ext_long |-> !rd_n[*6] ##[1:7] rd_n)
    else $error("rd width");
  chk_wr_short_width: assert property ($fell(wr_n) && !ext_long |-> !wr_n[*2] ##[1:4] wr_n)
    else $error("wr width");
  chk_wr_long_width: assert property ($fell(wr_n) && ext_long |-> !wr_n[*6] ##[1:7] wr_n)
    else $error("wr width");
  chk_rd_addr_lead: assert property ($fell(rd_n) |-> !addr_strobe_n &&
    bus_addr == $past(bus_addr) && bus_addr != $past(bus_addr, 2)) else $error("rd lead");
  chk_wr_addr_lead: assert property (wr_go |-> ext_long ? bus_addr == $past(bus_addr, 3) &&
    bus_addr != $past(bus_addr, 4) : bus_addr == $past(bus_addr, 2) &&
    bus_addr != $past(bus_addr, 3)) else $error("wr lead");
  chk_data_lead: assert property (wr_go |-> ext_long ? $past(bus_data_oe_n, 3) &&
    !$past(bus_data_oe_n, 2) : $past(bus_data_oe_n, 2) && !$past(bus_data_oe_n))
    else $error("data lead");
  chk_idle_release: assert property (rsp_valid |-> addr_strobe_n && rd_n && wr_n)
    else $error("release");
endmodule
bind gdb_bus_cycle gdb_bus_cycle_assertions u_chk(.*);
`default_nettype wire

// file: bench/gdb_periph.sv
`timescale 1ns/1ps
`default_nettype none
module gdb_periph(
  input wire logic clk,
  input wire logic rd_n,
  input wire logic [23:0] bus_addr,
  output logic [15:0] bus_data_i
);
  logic [15:0] junk = 16'h0000;
  always @(posedge clk) junk <= junk + 16'h3c3d;
  // answers only while read strobe is low
  assign bus_data_i = rd_n ? junk : bus_addr[15:0] ^ 16'h5a5a;
endmodule
`default_nettype wire

// file: bench/test_general_device_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
module test_general_device_bus_cycle;
  logic clk = 0, sys_rst = 1, write_setup_select = 0, ext_long = 0, req_valid = 0, req_write = 0;
  logic [3:0] short_width = 4'h2, long_width = 4'h6, n_low = 4'h0;
  logic [23:0] req_addr = 24'h000000, bus_addr;
  logic [15:0] req_wdata = 16'h0000, rsp_rdata, bus_data_o, bus_data_i, wd;
  logic req_ready, rsp_valid, addr_strobe_n, rd_n, wr_n, bus_data_oe_n;
  int errors = 0, n_checks = 0, cyc = 0, seed = 32'he6756582, n_cyc = 0, exp_cyc = 0;
  logic [3:0] w;
  gdb_bus_cycle DUT(.*);
  gdb_periph u_per(.clk(clk), .rd_n(rd_n), .bus_addr(bus_addr), .bus_data_i(bus_data_i));
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (!rd_n || !wr_n) n_low <= n_low + 4'h1;
    if (!wr_n) wd <= bus_data_o;
    if (cyc == 5000) begin errors++; stop_test(); end
  end
  task cmp(input logic [15:0] g, e);
    n_checks++;
    if (g !== e) begin errors++; $display("mismatch %0t %h %h", $time, g, e); end
  endtask
  task acc;
    {write_setup_select, ext_long, req_write} = 3'($random(seed));
    {short_width, long_width} = 8'($random(seed));
    req_addr = 24'($random(seed));
    req_wdata = 16'($random(seed));
    w = ext_long ? ((long_width > 5 && long_width < 13) ? long_width : 4'h6)
      : ((short_width > 1 && short_width < 6) ? short_width : 4'h2);
    exp_cyc = 1 + w + 1;
    if (req_write && write_setup_select) exp_cyc = (ext_long ? 3 : 2) + w + 1;
    n_low = 4'h0;
    n_cyc = 0;
    req_valid = 1;
    @(posedge clk) #1 req_valid = 0;
    while (rsp_valid !== 1'b1) begin
      @(posedge clk) #1;
      n_cyc++;
    end
    cmp(16'(n_cyc), 16'(exp_cyc));
    cmp({12'h000, n_low}, {12'h000, w});
    if (req_write) cmp(wd, req_wdata);
    else cmp(rsp_rdata, req_addr[15:0] ^ 16'h5a5a);
  endtask
  task stop_test;
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 sys_rst = 0;
    repeat (60) acc;
    stop_test();
  end
endmodule
`default_nettype wire

// file: rtl/gdb_bus_cycle.sv
// Overview of operation
// - address strobe lasts 2-5 cycles short, 6-12 long; 3-6 short, 8-14 long on setup writes
// - address leads address strobe by one cycle, with or without setup select
// - read strobe lasts 2-5 cycles short, 6-12 cycles long
// - address leads read strobe by one cycle in both lengths
// - write strobe lasts 2-5 cycles short, 6-12 cycles long
// - with setup select, address leads write strobe by 2 short, 3 long
// - with setup select, write data leads write strobe by 1 short, 2 long
// - with setup select, writes lengthen by one clock short, two long
`timescale 1ns/1ps
`default_nettype none
`include "gdb_map.svh"
module gdb_bus_cycle
  import gdb_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic write_setup_select,
  input wire logic ext_long,
  input wire logic [`GDB_CNT_W-1:0] short_width,
  input wire logic [`GDB_CNT_W-1:0] long_width,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [`GDB_ADDR_W-1:0] req_addr,
  input wire logic [`GDB_DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [`GDB_DATA_W-1:0] rsp_rdata,
  output logic [`GDB_ADDR_W-1:0] bus_addr,
  output logic addr_strobe_n,
  output logic rd_n,
  output logic wr_n,
  output logic [`GDB_DATA_W-1:0] bus_data_o,
  output logic bus_data_oe_n,
  input wire logic [`GDB_DATA_W-1:0] bus_data_i
);
  gdb_regs_t r_q, r_d;
  // decode helpers shared by the sequencer
  logic take;
  logic lead_last;
  logic data_due;
  logic width_last;

  // keep a requested width inside its legal range, else fall back to default
  function automatic logic [`GDB_CNT_W-1:0] clamp_w(
    input logic [`GDB_CNT_W-1:0] w,
    input logic [`GDB_CNT_W-1:0] lo,
    input logic [`GDB_CNT_W-1:0] hi,
    input logic [`GDB_CNT_W-1:0] def
  );
    if (w < lo) begin
      clamp_w = def;
    end else if (w > hi) begin
      clamp_w = def;
    end else begin
      clamp_w = w;
    end
  endfunction

  // strobe width for the access length in force
  function automatic logic [`GDB_CNT_W-1:0] strobe_w(
    input logic long_acc,
    input logic [`GDB_CNT_W-1:0] sw,
    input logic [`GDB_CNT_W-1:0] lw
  );
    if (long_acc) begin
      strobe_w = clamp_w(lw, `GDB_STB_LONG_MIN, `GDB_STB_LONG_MAX, `GDB_STB_LONG_DEF);
    end else begin
      strobe_w = clamp_w(sw, `GDB_STB_SHORT_MIN, `GDB_STB_SHORT_MAX, `GDB_STB_SHORT_DEF);
    end
  endfunction

  // cycles from address valid to the data strobe; setup writes lengthen the cycle
  function automatic logic [`GDB_CNT_W-1:0] addr_lead(
    input logic wr,
    input logic setup,
    input logic long_acc
  );
    if (!(wr && setup)) begin
      addr_lead = `GDB_LEAD_STD;
    end else if (long_acc) begin
      addr_lead = `GDB_LEAD_WR_LONG;
    end else begin
      addr_lead = `GDB_LEAD_WR_SHORT;
    end
  endfunction

  // cycles that write data stands ahead of the write strobe
  function automatic logic [`GDB_CNT_W-1:0] data_lead(
    input logic wr,
    input logic setup,
    input logic long_acc
  );
    if (!(wr && setup)) begin
      data_lead = `GDB_CNT_ZERO;
    end else if (long_acc) begin
      data_lead = `GDB_DLEAD_LONG;
    end else begin
      data_lead = `GDB_DLEAD_SHORT;
    end
  endfunction

  // read data is only latched from the bus on the last read strobe cycle
  function automatic logic [`GDB_DATA_W-1:0] capture_rd(
    input logic wr,
    input logic [`GDB_DATA_W-1:0] held,
    input logic [`GDB_DATA_W-1:0] bus
  );
    if (wr) begin
      capture_rd = held;
    end else begin
      capture_rd = bus;
    end
  endfunction

  // step a cycle counter down by one
  function automatic logic [`GDB_CNT_W-1:0] count_down(
    input logic [`GDB_CNT_W-1:0] c
  );
    count_down = c - `GDB_CNT_ONE;
  endfunction

  // all bus outputs come straight from the state register
  assign req_ready = (r_q.st == GDB_IDLE);
  assign rsp_valid = r_q.done;
  assign rsp_rdata = r_q.rdata;
  assign bus_addr = r_q.addr;
  assign addr_strobe_n = r_q.addr_strobe_n;
  assign rd_n = r_q.rd_n;
  assign wr_n = r_q.wr_n;
  assign bus_data_o = r_q.wdata;
  assign bus_data_oe_n = r_q.data_oe_n;
  assign take = req_valid && req_ready;
  assign lead_last = (r_q.lead == `GDB_CNT_ONE);
  assign data_due = (r_q.lead == r_q.dlead + `GDB_CNT_ONE);
  assign width_last = (r_q.width == `GDB_CNT_ONE);

  // one pass of the access sequencer per clock
  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    case (r_q.st)
      GDB_IDLE: begin
        r_d.addr_strobe_n = 1'b1;
        r_d.rd_n = 1'b1;
        r_d.wr_n = 1'b1;
        if (take) begin
          r_d.addr = req_addr;
          r_d.wr = req_write;
          r_d.wdata = req_wdata;
          r_d.width = strobe_w(ext_long, short_width, long_width);
          r_d.lead = addr_lead(req_write, write_setup_select, ext_long);
          r_d.dlead = data_lead(req_write, write_setup_select, ext_long);
          r_d.st = GDB_LEAD;
        end
      end
      GDB_LEAD: begin
        r_d.addr_strobe_n = 1'b0;
        if (r_q.wr && data_due) begin
          r_d.data_oe_n = 1'b0;
        end
        if (lead_last) begin
          r_d.rd_n = r_q.wr;
          r_d.wr_n = !r_q.wr;
          r_d.st = GDB_STROBE;
        end else begin
          r_d.lead = count_down(r_q.lead);
        end
      end
      GDB_STROBE: begin
        if (width_last) begin
          r_d.addr_strobe_n = 1'b1;
          r_d.rd_n = 1'b1;
          r_d.wr_n = 1'b1;
          r_d.rdata = capture_rd(r_q.wr, r_q.rdata, bus_data_i);
          r_d.st = GDB_RECOVER;
        end else begin
          r_d.width = count_down(r_q.width);
        end
      end
      GDB_RECOVER: begin
        r_d.addr_strobe_n = 1'b1;
        r_d.rd_n = 1'b1;
        r_d.wr_n = 1'b1;
        r_d.data_oe_n = 1'b1;
        r_d.done = 1'b1;
        r_d.st = GDB_IDLE;
      end
      default: begin
        r_d.st = GDB_IDLE;
        r_d.addr_strobe_n = 1'b1;
        r_d.rd_n = 1'b1;
        r_d.wr_n = 1'b1;
        r_d.data_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_q.st <= GDB_IDLE;
      r_q.lead <= `GDB_CNT_ZERO;
      r_q.dlead <= `GDB_CNT_ZERO;
      r_q.width <= `GDB_CNT_ZERO;
      r_q.wr <= 1'b0;
      r_q.addr <= `GDB_ADDR_RST;
      r_q.wdata <= `GDB_DATA_RST;
      r_q.rdata <= `GDB_DATA_RST;
      r_q.addr_strobe_n <= 1'b1;
      r_q.rd_n <= 1'b1;
      r_q.wr_n <= 1'b1;
      r_q.data_oe_n <= 1'b1;
      r_q.done <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end
endmodule
`default_nettype wire

// file: rtl/gdb_map.svh
`ifndef GDB_MAP_SVH
`define GDB_MAP_SVH
`define GDB_ADDR_W 24
`define GDB_DATA_W 16
`define GDB_CNT_W 4
`define GDB_CNT_ONE 4'h1
`define GDB_CNT_ZERO 4'h0
`define GDB_ADDR_RST 24'h000000
`define GDB_DATA_RST 16'h0000
// strobe widths in clock cycles, short and long access
`define GDB_STB_SHORT_DEF 4'h2
`define GDB_STB_LONG_DEF 4'h6
`define GDB_STB_SHORT_MIN 4'h2
`define GDB_STB_SHORT_MAX 4'h5
`define GDB_STB_LONG_MIN 4'h6
`define GDB_STB_LONG_MAX 4'hc
// address lead ahead of a strobe
`define GDB_LEAD_STD 4'h1
`define GDB_LEAD_WR_SHORT 4'h2
`define GDB_LEAD_WR_LONG 4'h3
// write data lead ahead of the write strobe
`define GDB_DLEAD_SHORT 4'h1
`define GDB_DLEAD_LONG 4'h2
`endif

// file: rtl/gdb_pkg.sv
package gdb_pkg;
  `include "gdb_map.svh"
  typedef enum logic [2:0] {
    GDB_IDLE,
    GDB_LEAD,
    GDB_STROBE,
    GDB_RECOVER
  } gdb_state_t;
  typedef struct packed {
    gdb_state_t st;
    logic [`GDB_CNT_W-1:0] lead;
    logic [`GDB_CNT_W-1:0] dlead;
    logic [`GDB_CNT_W-1:0] width;
    logic wr;
    logic [`GDB_ADDR_W-1:0] addr;
    logic [`GDB_DATA_W-1:0] wdata;
    logic [`GDB_DATA_W-1:0] rdata;
    logic addr_strobe_n;
    logic rd_n;
    logic wr_n;
    logic data_oe_n;
    logic done;
  } gdb_regs_t;
endpackage
